// file: rtl/tas_pkg.sv
// Constants, state encoding and state record of the test access port select block.
package tas_pkg;

  localparam int unsigned IR_W = 4;
  localparam int unsigned DR_W = 32;

  localparam logic [IR_W-1:0] IR_IDCODE  = 4'h1;
  localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // Identification word; the value is arbitrary, bit 0 set as the scan convention wants.
  localparam logic [DR_W-1:0] TAS_IDCODE = 32'h0A5C_3001;

  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SELDR, TAP_CAPDR, TAP_SHDR, TAP_EX1DR, TAP_PADR, TAP_EX2DR,
    TAP_UPDR, TAP_SELIR, TAP_CAPIR, TAP_SHIR, TAP_EX1IR, TAP_PAIR, TAP_EX2IR, TAP_UPIR
  } tas_tap_t;

  typedef struct packed {
    logic            tckS1;
    logic            tckS2;
    logic            tckS3;
    logic            tmsS1;
    logic            tmsS2;
    logic            tdiS1;
    logic            tdiS2;
    logic            trstS1;
    logic            trstS2;
    logic            trstS3;
    logic            selS1;
    logic            selS2;
    tas_tap_t        tap;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] irShift;
    logic [DR_W-1:0] drShift;
    logic            debugSel;
    logic            tdo;
    logic            tdoEn;
    logic            returned_test_clock;
  } tas_state_t;

  localparam tas_state_t TAS_RESET = '{tap: TAP_TLR, ir: IR_IDCODE, debugSel: 1'b1,
                                       trstS1: 1'b1, trstS2: 1'b1, trstS3: 1'b1,
                                       selS1: 1'b1, selS2: 1'b1, default: '0};

endpackage

// file: rtl/tas_top.sv
// Test access port controller with controller select, sampled on the system clock.
// Summary of operation
// - Low test reset forces the controller to its initial state without test clock edges.
// - While the debug controller is selected, serial data output changes only on falling test clock edges.
// - Serial data input is captured on rising test clock edges in the shift states.
// - Mode select is sampled on rising test clock edges to advance the state machine.
// - State and shift registers advance only on rising test clock edges, except when test reset forces them.
// - Controller select is latched when test reset rises; it chooses the controller.
// - Returned test clock output, unusable while the pin serves the single-wire interface.
`timescale 1ns/100ps
`default_nettype none

module tas_top
  import tas_pkg::*;
(
  // System clock and reset.
  input  wire logic clk,
  input  wire logic srst,
  // Test port pins from the debugger.
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic trstN,
  input  wire logic ctrlSel,
  output var  logic tdo,
  output var  logic tdoEn,
  // Shared pin use and returned clock.
  input  wire logic wireMode,
  output var  logic returnedTestClock,
  // Factory test controller hookup.
  input  wire logic factoryTdo,
  input  wire logic factoryTdoEn,
  output var  logic debugSelected
);

  tas_state_t st_r;
  tas_state_t st_nxt;
  logic       rise;
  logic       fall;

  // Edges are taken from the second and third stages, never from the first.
  assign rise = st_r.tckS2 & ~st_r.tckS3;
  assign fall = ~st_r.tckS2 & st_r.tckS3;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.tckS1  = tck;
    st_nxt.tckS2  = st_r.tckS1;
    st_nxt.tckS3  = st_r.tckS2;
    st_nxt.tmsS1  = tms;
    st_nxt.tmsS2  = st_r.tmsS1;
    st_nxt.tdiS1  = tdi;
    st_nxt.tdiS2  = st_r.tdiS1;
    st_nxt.trstS1 = trstN;
    st_nxt.trstS2 = st_r.trstS1;
    st_nxt.trstS3 = st_r.trstS2;
    st_nxt.selS1  = ctrlSel;
    st_nxt.selS2  = st_r.selS1;
    if (!st_r.trstS2) begin
      st_nxt.tap = TAP_TLR;
      st_nxt.ir  = IR_IDCODE;
    end else if (rise) begin
      case (st_r.tap)
        TAP_TLR: begin
          st_nxt.ir  = IR_IDCODE;
          st_nxt.tap = st_r.tmsS2 ? TAP_TLR : TAP_RTI;
        end
        TAP_RTI:   st_nxt.tap = st_r.tmsS2 ? TAP_SELDR : TAP_RTI;
        TAP_SELDR: st_nxt.tap = st_r.tmsS2 ? TAP_SELIR : TAP_CAPDR;
        TAP_CAPDR: begin
          st_nxt.drShift = (st_r.ir == IR_IDCODE) ? TAS_IDCODE : '0;
          st_nxt.tap     = st_r.tmsS2 ? TAP_EX1DR : TAP_SHDR;
        end
        TAP_SHDR: begin
          // Anything but the identification word acts as the one-bit bypass path.
          if (st_r.ir == IR_IDCODE) begin
            st_nxt.drShift = {st_r.tdiS2, st_r.drShift[DR_W-1:1]};
          end else begin
            st_nxt.drShift[0] = st_r.tdiS2;
          end
          st_nxt.tap = st_r.tmsS2 ? TAP_EX1DR : TAP_SHDR;
        end
        TAP_EX1DR: st_nxt.tap = st_r.tmsS2 ? TAP_UPDR : TAP_PADR;
        TAP_PADR:  st_nxt.tap = st_r.tmsS2 ? TAP_EX2DR : TAP_PADR;
        TAP_EX2DR: st_nxt.tap = st_r.tmsS2 ? TAP_UPDR : TAP_SHDR;
        TAP_UPDR:  st_nxt.tap = st_r.tmsS2 ? TAP_SELDR : TAP_RTI;
        TAP_SELIR: st_nxt.tap = st_r.tmsS2 ? TAP_TLR : TAP_CAPIR;
        TAP_CAPIR: begin
          st_nxt.irShift = IR_CAPTURE;
          st_nxt.tap     = st_r.tmsS2 ? TAP_EX1IR : TAP_SHIR;
        end
        TAP_SHIR: begin
          st_nxt.irShift = {st_r.tdiS2, st_r.irShift[IR_W-1:1]};
          st_nxt.tap     = st_r.tmsS2 ? TAP_EX1IR : TAP_SHIR;
        end
        TAP_EX1IR: st_nxt.tap = st_r.tmsS2 ? TAP_UPIR : TAP_PAIR;
        TAP_PAIR:  st_nxt.tap = st_r.tmsS2 ? TAP_EX2IR : TAP_PAIR;
        TAP_EX2IR: st_nxt.tap = st_r.tmsS2 ? TAP_UPIR : TAP_SHIR;
        TAP_UPIR: begin
          st_nxt.ir  = st_r.irShift;
          st_nxt.tap = st_r.tmsS2 ? TAP_SELDR : TAP_RTI;
        end
        default:   st_nxt.tap = TAP_TLR;
      endcase
    end
    if (st_r.trstS2 && !st_r.trstS3) begin
      st_nxt.debugSel = st_r.selS2;
    end
    if (!st_r.debugSel) begin
      // The factory controller owns the data pin entirely.
      st_nxt.tdo   = factoryTdo;
      st_nxt.tdoEn = factoryTdoEn;
    end else if (st_r.tap == TAP_TLR) begin
      // An enable left high by the factory path must not wait for a test clock to drop.
      st_nxt.tdoEn = 1'b0;
    end else if (fall) begin
      st_nxt.tdoEn = (st_r.tap == TAP_SHIR) || (st_r.tap == TAP_SHDR);
      st_nxt.tdo   = (st_r.tap == TAP_SHIR) ? st_r.irShift[0] : st_r.drShift[0];
    end
    // The returned clock lags the pin by the synchroniser, which is what pacing needs.
    st_nxt.returned_test_clock = wireMode ? 1'b0 : st_r.tckS2;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= TAS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tdo               = st_r.tdo;
  assign tdoEn             = st_r.tdoEn;
  assign returnedTestClock = st_r.returned_test_clock;
  assign debugSelected     = st_r.debugSel;

  // The checks run on the system clock, so each test pin event is seen two cycles late.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_trst_init;
    !st_r.trstS2 |=> (st_r.tap == TAP_TLR) && (st_r.ir == IR_IDCODE);
  endproperty
  a_trst_init: assert property (p_trst_init) else $error("Test reset did not init.");

  property p_idle_quiet;
    (st_r.debugSel && st_r.tap == TAP_TLR) |=> !st_r.tdoEn;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Data out driven in reset.");

  property p_tdo_fall;
    ($changed(st_r.tdo) && st_r.debugSel && $past(st_r.debugSel)) |-> $past(fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("Data out moved off a falling edge.");

  property p_tdo_data;
    (fall && st_r.debugSel && st_r.tap == TAP_SHDR) |=>
      st_r.tdoEn && (st_r.tdo == $past(st_r.drShift[0]));
  endproperty
  a_tdo_data: assert property (p_tdo_data) else $error("Data out bit wrong.");

  property p_tdi_capture;
    (rise && st_r.trstS2 && st_r.tap == TAP_SHIR) |=>
      st_r.irShift[IR_W-1] == $past(st_r.tdiS2);
  endproperty
  a_tdi_capture: assert property (p_tdi_capture) else $error("Data in not captured.");

  property p_dr_capture;
    (rise && st_r.trstS2 && st_r.tap == TAP_SHDR && st_r.ir == IR_IDCODE) |=>
      st_r.drShift[DR_W-1] == $past(st_r.tdiS2);
  endproperty
  a_dr_capture: assert property (p_dr_capture) else $error("Data bit not shifted in.");

  property p_tms_advance;
    (rise && st_r.trstS2 && st_r.tap == TAP_TLR) |=>
      st_r.tap == ($past(st_r.tmsS2) ? TAP_TLR : TAP_RTI);
  endproperty
  a_tms_advance: assert property (p_tms_advance) else $error("Mode select ignored.");

  property p_no_edge_hold;
    (!rise && st_r.trstS2) |=>
      $stable(st_r.tap) && $stable(st_r.ir) && $stable(st_r.irShift);
  endproperty
  a_no_edge_hold: assert property (p_no_edge_hold) else $error("Moved without a test edge.");

  property p_sel_latch;
    (st_r.trstS2 && !st_r.trstS3) |=>
      st_r.debugSel == $past(st_r.selS2) ##1 $stable(st_r.debugSel)[*2];
  endproperty
  a_sel_latch: assert property (p_sel_latch) else $error("Select not latched.");

  property p_sel_hold;
    $changed(st_r.debugSel) |-> $past(st_r.trstS2 && !st_r.trstS3);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("Select moved without reset release.");

  property p_factory_pass;
    !st_r.debugSel |=>
      (st_r.tdo == $past(factoryTdo)) && (st_r.tdoEn == $past(factoryTdoEn));
  endproperty
  a_factory_pass: assert property (p_factory_pass) else $error("Factory path not routed.");

  property p_returned_test_clock;
    wireMode |=> (returnedTestClock == 1'b0) || !$past(wireMode);
  endproperty
  a_returned_test_clock: assert property (p_returned_test_clock) else $error("Returned clock on while pin shared.");

  property p_returned_test_clock_follow;
    !wireMode |=> returnedTestClock == $past(st_r.tckS2);
  endproperty
  a_returned_test_clock_follow: assert property (p_returned_test_clock_follow) else $error("Returned clock not following.");

  property p_dr_load;
    (rise && st_r.trstS2 && st_r.tap == TAP_CAPDR && st_r.ir == IR_IDCODE) |=>
      st_r.drShift == TAS_IDCODE;
  endproperty
  a_dr_load: assert property (p_dr_load) else $error("Identification word not loaded.");

  property p_ir_update;
    (rise && st_r.trstS2 && st_r.tap == TAP_UPIR) |=> st_r.ir == $past(st_r.irShift);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("Instruction not updated.");

endmodule // tas_top

`default_nettype wire

// file: testbench/tas_dbg_model.sv
// Debugger model that drives the test port pins and samples the returned data.
`timescale 1ns/100ps
`default_nettype none
module tas_dbg_model (
  // Clock that places pin changes.
  input  wire logic clk,
  // Test port pins.
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  input  wire logic tdo,
  // Sampled data bit.
  output var  logic bitSeen,
  output var  logic bitVal
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    bitSeen = 1'b0;
    bitVal = 1'b0;
  end
  // One test clock of 160 ns; it stays low between calls.
  task automatic step(input logic m, input logic d, input logic smp);
    tms = m;
    tdi = d;
    repeat (20) @(negedge clk);
    tck = 1'b1;
    bitVal = tdo;
    bitSeen = smp;
    repeat (20) @(negedge clk);
    tck = 1'b0;
    bitSeen = 1'b0;
  endtask
endmodule // tas_dbg_model
`default_nettype wire

// file: testbench/tb_tas_top.sv
// Self-checking bench of the test access port select block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_tas_top import tas_pkg::*; ();
  logic        clk = 1'b0, srst = 1'b1, trstN = 1'b0, ctrlSel = 1'b1;
  logic        wireMode = 1'b0, fTdo = 1'b0, fTdoEn = 1'b0, e;
  logic        tck, tms, tdi, tdo, tdoEn, returned_test_clock, dbgSel, bitSeen, bitVal;
  logic [31:0] rnd = 32'h0001_0536;
  logic        expQ[$];
  int          errors = 0, check_count = 0;
  always #2 clk = ~clk;
  tas_top uut (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
    .ctrlSel(ctrlSel), .tdo(tdo), .tdoEn(tdoEn), .wireMode(wireMode),
    .returnedTestClock(returned_test_clock), .factoryTdo(fTdo), .factoryTdoEn(fTdoEn),
    .debugSelected(dbgSel));
  tas_dbg_model dbg (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .bitSeen(bitSeen), .bitVal(bitVal));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge bitSeen) if (expQ.size() > 0) begin
    e = expQ.pop_front();
    `CHK(bitVal, e)
    `CHK(tdoEn, 1'b1)
  end
  // Enters the shift state from idle, shifts n bits, then returns to idle.
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      input logic [63:0] ex);
    dbg.step(1'b1, 1'b0, 1'b0);
    if (ir) dbg.step(1'b1, 1'b0, 1'b0);
    dbg.step(1'b0, 1'b0, 1'b0);
    dbg.step(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      expQ.push_back(ex[i]);
      dbg.step(i == n - 1, din[i], 1'b1);
    end
    dbg.step(1'b1, 1'b0, 1'b0);
    dbg.step(1'b0, 1'b0, 1'b0);
  endtask
  // Test reset with no test clock; the select is latched at release.
  task automatic pulseTrst(input logic sel);
    @(negedge clk) trstN = 1'b0;
    ctrlSel = sel;
    repeat (10) @(negedge clk);
    trstN = 1'b1;
    repeat (10) @(negedge clk);
    `CHK(dbgSel, sel)
    `CHK(tdoEn, fTdoEn & ~sel)
  endtask
  task automatic summarize();
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    pulseTrst(1'b1);
    dbg.step(1'b0, 1'b0, 1'b0);
    scan(1'b0, 64, {rnd, lfsr(rnd)}, {lfsr(rnd), TAS_IDCODE});
    rnd = lfsr(lfsr(rnd));
    scan(1'b1, 4, {60'h0, IR_BYPASS}, {60'h0, IR_CAPTURE});
    scan(1'b0, 8, {32'h0, rnd}, {56'h0, rnd[6:0], 1'b0});
    pulseTrst(1'b0);
    fTdo = 1'b1;
    fTdoEn = 1'b1;
    repeat (6) @(negedge clk);
    `CHK({tdo, tdoEn}, 2'h3)
    pulseTrst(1'b1);
    dbg.step(1'b0, 1'b0, 1'b0);
    scan(1'b0, 32, 64'h0, {32'h0, TAS_IDCODE});
    for (int w = 0; w < 2; w++) begin
      wireMode = w[0];
      fork
        dbg.step(1'b0, 1'b0, 1'b0);
        begin
          repeat (30) @(negedge clk);
          `CHK(returned_test_clock, ~w[0])
        end
      join
    end
    summarize();
  end
  // The whole run needs about 22 us.
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule // tb_tas_top
`default_nettype wire
